// File: logic/dpw_pkg.sv
// package: register layout, keys and timing counts of the watchdog channel
package dpw_pkg;
  // word write keys, carried in the upper byte
  localparam logic [7:0] KEY_COUNTER = 8'h5A;
  localparam logic [7:0] KEY_CONTROL = 8'hA5;
  // read select values
  localparam logic RD_SEL_CONTROL = 1'b0;
  localparam logic RD_SEL_COUNTER = 1'b1;
  // field positions of the control/status register
  localparam int FLAG_POS = 7;
  localparam int MODE_POS = 6;
  localparam int ENABLE_POS = 5;
  localparam int SRC_POS = 4;
  localparam int ACTION_POS = 3;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNTER_RESET = 8'h00;
  localparam logic [7:0] COUNTER_MAX = 8'hFF;
  // internal reset and reset pin low time, in system clocks
  localparam logic [9:0] RESET_CYCLES = 10'h206;     // 518
  localparam logic [9:0] PIN_LOW_CYCLES = 10'h084;   // 132
  localparam logic [9:0] PIN_LOW_END = RESET_CYCLES - PIN_LOW_CYCLES;
  // main prescaler: log2 of divisor per code; code 0 is divide by two
  localparam logic [3:0] MAIN_LOG2 [8] = '{4'h1, 4'h6, 4'h7, 4'h9,
                                          4'hB, 4'hD, 4'hF, 4'hF};

  typedef enum logic {
    MODE_INTERVAL = 1'b0,
    MODE_WATCHDOG = 1'b1
  } dpw_mode_t;

  typedef struct packed {
    logic overflow_flag;
    dpw_mode_t timer_mode_select;
    logic count_enable_bit;
    logic prescaler_source_select;
    logic overflow_action_select;
    logic clock_divider_select_hi;
    logic clock_divider_select_mid;
    logic clock_divider_select_lo;
  } dpw_csr_t;

  typedef struct packed {
    logic wr;
    logic wr_word;
    logic [15:0] wdata;
    logic rd;
    logic rd_sel;
  } dpw_bus_t;
endpackage

// File: logic/dpw_watchdog.sv
// module: second watchdog / interval timer channel with two prescalers
`timescale 1ns/1ps
// Behaviour
// [RULE_01] overflow flag sets when the counter wraps from FF to 00
// [RULE_02] internal reset caused by overflow clears the flag itself
// [RULE_03] flag clears only after a read seeing 1, then writing 0
// [RULE_04] writing 0 to count enable also clears the flag
// [RULE_05] mode bit 0 is interval timer, 1 is watchdog
// [RULE_06] counter advances on each selected tick while enabled
// [RULE_07] clearing count enable stops the counter and zeroes it
// [RULE_08] source bit 0 takes main prescaler, 1 takes sub prescaler
// [RULE_09] action bit 0 requests NMI, 1 requests internal reset
// [RULE_10] main prescaler code 000 ticks at system clock over two
// [RULE_11] sub prescaler codes 000..111 divide sub clock by 2..256
// [RULE_12] writes of 1 to the flag are ignored
// [RULE_13] software polling without interrupt reads the flag twice
// [RULE_14] counter is eight bits, readable and writable
// [RULE_15] word writes only; upper byte 5A counter, A5 control
// [RULE_16] internal reset 518 clocks, reset pin low 132 clocks
// [RULE_17] interval interrupt rises in the cycle the flag sets
// [RULE_18] main prescaler codes 001..111 come from a divisor table
// [RULE_19] all control fields reset to zero
module dpw_watchdog (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // cpu register access
  input wire dpw_pkg::dpw_bus_t bus,
  output logic [7:0] bus_rdata_q,
  // sub clock pin
  input wire logic sub_clk,
  // requests
  output logic interval_overflow_irq_q,
  output logic nmi_req_q,
  output logic internal_reset_q,
  output logic reset_output_pin_n_q
);

  ////////////////////////////////////////////////////////////////////////////
  // decode

  dpw_pkg::dpw_csr_t csr_q;
  dpw_pkg::dpw_csr_t csr_wr;
  logic [7:0] count_q;
  logic wr_count;
  logic wr_csr;
  logic [2:0] div_code;
  logic [15:0] main_pre_q;
  logic [7:0] sub_pre_q;
  logic [2:0] sub_sync_q;
  logic sub_edge;
  logic main_tick;
  logic sub_tick;
  logic tick;
  logic overflow;
  logic clear_armed_q;
  logic flag_d;
  logic [9:0] rst_cnt_q;
  logic rst_start;

  // byte writes are dropped: both keys need the whole word
  assign wr_count = bus.wr && bus.wr_word &&
                    bus.wdata[15:8] == dpw_pkg::KEY_COUNTER;  // see [RULE_15]
  assign wr_csr = bus.wr && bus.wr_word &&
                  bus.wdata[15:8] == dpw_pkg::KEY_CONTROL;    // see [RULE_15]
  assign csr_wr = dpw_pkg::dpw_csr_t'(bus.wdata[7:0]);
  assign div_code = {csr_q.clock_divider_select_hi,
                     csr_q.clock_divider_select_mid,
                     csr_q.clock_divider_select_lo};

  ////////////////////////////////////////////////////////////////////////////
  // prescalers

  // main prescaler runs free; tick when the low log2 bits are all ones
  always_ff @(posedge core_clk) begin
    if (srst) begin
      main_pre_q <= 16'h0000;
    end else begin
      main_pre_q <= main_pre_q + 16'h0001;
    end
  end

  assign main_tick = &(main_pre_q |
                       ~((16'h0001 << dpw_pkg::MAIN_LOG2[div_code]) -
                         16'h0001));  // see [RULE_10] see [RULE_18]

  // sub clock pin: two flops before use, third only for the edge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sub_sync_q <= 3'h0;
    end else begin
      sub_sync_q <= {sub_sync_q[1:0], sub_clk};
    end
  end

  assign sub_edge = sub_sync_q[1] && !sub_sync_q[2];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sub_pre_q <= 8'h00;
    end else if (sub_edge) begin
      sub_pre_q <= sub_pre_q + 8'h01;
    end
  end

  // code n divides the sub clock by 2^(n+1)
  assign sub_tick = sub_edge &&
                    &(sub_pre_q | ~((8'h02 << div_code) - 8'h01));
                    // see [RULE_11]

  assign tick = csr_q.prescaler_source_select ? sub_tick
                                              : main_tick;  // see [RULE_08]

  ////////////////////////////////////////////////////////////////////////////
  // counter

  // a counter write in the same cycle as a tick wins over the increment
  assign overflow = tick && csr_q.count_enable_bit && !wr_count &&
                    count_q == dpw_pkg::COUNTER_MAX;         // see [RULE_01]

  always_ff @(posedge core_clk) begin
    if (srst || rst_start) begin
      count_q <= dpw_pkg::COUNTER_RESET;
    end else if (!csr_q.count_enable_bit) begin
      count_q <= dpw_pkg::COUNTER_RESET;                    // see [RULE_07]
      if (wr_count) begin
        count_q <= bus.wdata[7:0];                          // see [RULE_14]
      end
    end else if (wr_count) begin
      count_q <= bus.wdata[7:0];                            // see [RULE_14]
    end else if (tick) begin
      count_q <= count_q + 8'h01;                           // see [RULE_06]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control/status and overflow flag

  always_ff @(posedge core_clk) begin
    if (srst || rst_start) begin
      csr_q <= dpw_pkg::dpw_csr_t'(dpw_pkg::CONTROL_RESET);  // see [RULE_19]
    end else begin
      csr_q.overflow_flag <= flag_d;
      if (wr_csr) begin
        csr_q.timer_mode_select <= csr_wr.timer_mode_select;   // see [RULE_05]
        csr_q.count_enable_bit <= csr_wr.count_enable_bit;
        csr_q.prescaler_source_select <= csr_wr.prescaler_source_select;
        csr_q.overflow_action_select <= csr_wr.overflow_action_select;
        csr_q.clock_divider_select_hi <= csr_wr.clock_divider_select_hi;
        csr_q.clock_divider_select_mid <= csr_wr.clock_divider_select_mid;
        csr_q.clock_divider_select_lo <= csr_wr.clock_divider_select_lo;
      end
    end
  end

  // set beats clear; a write of 1 never sets the flag
  always_comb begin
    flag_d = csr_q.overflow_flag;
    if (wr_csr && !csr_wr.count_enable_bit) begin
      flag_d = 1'b0;                                        // see [RULE_04]
    end else if (wr_csr && clear_armed_q && !csr_wr.overflow_flag) begin
      flag_d = 1'b0;                                  // see [RULE_03] [RULE_12]
    end
    if (overflow) begin
      flag_d = 1'b1;                                        // see [RULE_01]
    end
  end

  // arm the clear on a control read that sees the flag set
  always_ff @(posedge core_clk) begin
    if (srst || rst_start) begin
      clear_armed_q <= 1'b0;
    end else if (!csr_q.overflow_flag || wr_csr) begin
      clear_armed_q <= 1'b0;
    end else if (bus.rd && bus.rd_sel == dpw_pkg::RD_SEL_CONTROL) begin
      clear_armed_q <= 1'b1;                                // see [RULE_03]
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      bus_rdata_q <= 8'h00;
    end else if (bus.rd) begin
      bus_rdata_q <= (bus.rd_sel == dpw_pkg::RD_SEL_COUNTER) ? count_q
                                                            : 8'(csr_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overflow requests

  always_ff @(posedge core_clk) begin
    if (srst || rst_start) begin
      interval_overflow_irq_q <= 1'b0;
    end else begin
      interval_overflow_irq_q <= flag_d &&
        csr_q.timer_mode_select == dpw_pkg::MODE_INTERVAL;  // see [RULE_17]
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      nmi_req_q <= 1'b0;
    end else begin
      nmi_req_q <= overflow && !csr_q.overflow_action_select &&
        csr_q.timer_mode_select == dpw_pkg::MODE_WATCHDOG;   // see [RULE_09]
    end
  end

  // full count stands only in the cycle after the overflow edge, so the
  // channel and its flag clear at the same edge the reset pulse starts
  assign rst_start = rst_cnt_q == dpw_pkg::RESET_CYCLES;     // see [RULE_02]

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rst_cnt_q <= 10'h000;
    end else if (overflow && csr_q.overflow_action_select &&
                 csr_q.timer_mode_select == dpw_pkg::MODE_WATCHDOG) begin
      rst_cnt_q <= dpw_pkg::RESET_CYCLES;                   // see [RULE_09]
    end else if (rst_cnt_q != 10'h000) begin
      rst_cnt_q <= rst_cnt_q - 10'h001;
    end
  end

  // outputs lag the counter by one edge so both stand exact lengths
  always_ff @(posedge core_clk) begin
    if (srst) begin
      internal_reset_q <= 1'b0;
      reset_output_pin_n_q <= 1'b1;
    end else begin
      internal_reset_q <= rst_cnt_q != 10'h000;             // see [RULE_16]
      reset_output_pin_n_q <=
        !(rst_cnt_q > dpw_pkg::PIN_LOW_END);                // see [RULE_16]
    end
  end

endmodule // dpw_watchdog

// File: verif/dpw_watchdog_checker.sv
// checker: port assertions for the watchdog channel
`timescale 1ns/1ps
module dpw_watchdog_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // bus and requests
  input wire dpw_pkg::dpw_bus_t bus,
  input wire logic [7:0] bus_rdata_q,
  input wire logic sub_clk,
  input wire logic interval_overflow_irq_q,
  input wire logic nmi_req_q,
  input wire logic internal_reset_q,
  input wire logic reset_output_pin_n_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [9:0] rst_len_q;
  logic [9:0] pin_len_q;
  logic ctl_wr;
  assign ctl_wr = bus.wr && bus.wr_word
    && bus.wdata[15:8] == dpw_pkg::KEY_CONTROL;
  ////////////////////////////////////////
  // pulse lengths, counted while active
  always_ff @(posedge core_clk) begin
    if (srst || !internal_reset_q) rst_len_q <= 10'h000;
    else rst_len_q <= rst_len_q + 10'h001;
  end
  always_ff @(posedge core_clk) begin
    if (srst || reset_output_pin_n_q) pin_len_q <= 10'h000;
    else pin_len_q <= pin_len_q + 10'h001;
  end
  ////////////////////////////////////////
  AST_RST_LEN: assert property ($fell(internal_reset_q) |->
    rst_len_q == dpw_pkg::RESET_CYCLES) else $error("reset length");
  AST_PIN_LEN: assert property ($rose(reset_output_pin_n_q)
    |-> pin_len_q == dpw_pkg::PIN_LOW_CYCLES) else $error("pin low length");
  AST_PIN_WITH_RST: assert property ($rose(internal_reset_q)
    |-> $fell(reset_output_pin_n_q)) else $error("pin not with reset");
  AST_NMI_PULSE: assert property (nmi_req_q |=> !nmi_req_q)
    else $error("nmi too long");
  AST_NMI_ALONE: assert property (nmi_req_q
    |-> !internal_reset_q && reset_output_pin_n_q)
    else $error("nmi with reset");
  AST_IRQ_HOLD: assert property (interval_overflow_irq_q
    && !ctl_wr |=> interval_overflow_irq_q) else $error("irq dropped");
  AST_IRQ_W1: assert property (interval_overflow_irq_q
    && ctl_wr && bus.wdata[7:5] == 3'h5 |=> interval_overflow_irq_q)
    else $error("flag cleared by one");
  AST_STOP_CLEARS: assert property (ctl_wr && !bus.wdata[5]
    |=> !interval_overflow_irq_q) else $error("stop kept flag");
  AST_RST_CLEARS: assert property (bus.rd && !bus.rd_sel
    && internal_reset_q |=> bus_rdata_q == dpw_pkg::CONTROL_RESET)
    else $error("not cleared");
  AST_RDATA_HOLD: assert property (!bus.rd
    |=> $stable(bus_rdata_q)) else $error("rdata moved");
endmodule // dpw_watchdog_checker
bind dpw_watchdog dpw_watchdog_checker dpw_watchdog_checker_i (
  .core_clk(core_clk), .srst(srst), .bus(bus), .bus_rdata_q(bus_rdata_q),
  .sub_clk(sub_clk), .interval_overflow_irq_q(interval_overflow_irq_q),
  .nmi_req_q(nmi_req_q), .internal_reset_q(internal_reset_q),
  .reset_output_pin_n_q(reset_output_pin_n_q));

// File: verif/dpw_watchdog_tb.sv
// bench: random and corner tests of the watchdog channel
`timescale 1ns/1ps
module dpw_watchdog_tb;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic sub_clk = 1'b0;
  logic run = 1'b0;
  dpw_pkg::dpw_bus_t bus = '0;
  logic [7:0] rdata;
  logic irq, nmi, irst, pin_n;
  logic [7:0] v, got;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  int subs = 0;
  int n;
  int d;
  always #2 core_clk = ~core_clk;
  // sub clock gated so it cannot tick during register checks
  always #20 if (run) sub_clk = ~sub_clk;
  always @(posedge sub_clk) subs++;
  dpw_watchdog dpw_watchdog_i (.core_clk(core_clk), .srst(srst), .bus(bus),
    .bus_rdata_q(rdata), .sub_clk(sub_clk), .interval_overflow_irq_q(irq),
    .nmi_req_q(nmi), .internal_reset_q(irst), .reset_output_pin_n_q(pin_n));
  ////////////////////////////////////////
  task automatic test_done();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      test_done();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc1();
    @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] k, input logic [7:0] d,
                    input logic w = 1'b1);
    bus = '{1'b1, w, {k, d}, 1'b0, 1'b0};
    cyc1();
    bus = '0;
    cyc1();
  endtask
  task automatic rd(input logic s, output logic [7:0] d);
    bus = '{1'b0, 1'b0, 16'h0000, 1'b1, s};
    cyc1();
    bus = '0;
    d = rdata;
    cyc1();
  endtask
  // bounded wait: 0 irq, 1 nmi, 2 internal reset
  task automatic wt(input int w, input int lim);
    n = 0;
    while (((({irst, nmi, irq} >> w) & 3'h1) !== 3'h1) && n < lim) begin
      cyc1();
      n++;
    end
    chk(8'(n < lim), 8'h01);
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(82));
    repeat (5) @(posedge core_clk);
    #1 srst = 1'b0;
    rd(1'b0, got);
    chk(got, dpw_pkg::CONTROL_RESET);
    wr(dpw_pkg::KEY_CONTROL, 8'h37);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(dpw_pkg::KEY_COUNTER, v);
      wr(dpw_pkg::KEY_COUNTER, ~v, 1'b0);
      wr(8'h5B, ~v);
      rd(1'b1, got);
      chk(got, v);
    end
    wr(dpw_pkg::KEY_CONTROL, 8'h17);
    rd(1'b1, got);
    chk(got, 8'h00);
    rd(1'b0, got);
    chk(got, 8'h17);
    // main prescaler, code 0: 256 ticks of two clocks each
    wr(dpw_pkg::KEY_CONTROL, 8'h20);
    wr(dpw_pkg::KEY_COUNTER, 8'h00);
    wt(0, 600);
    chk(8'(n >= 508 && n <= 515), 8'h01);
    rd(1'b0, got);
    chk(got, 8'hA0);
    wr(dpw_pkg::KEY_CONTROL, 8'hA0);
    wr(dpw_pkg::KEY_CONTROL, 8'h20);
    chk({7'h00, irq}, 8'h01);
    // polled clear: the flag is read as set twice before the zero write
    rd(1'b0, got);
    chk(got, 8'hA0);
    rd(1'b0, got);
    chk(got, 8'hA0);
    wr(dpw_pkg::KEY_CONTROL, 8'h20);
    chk({7'h00, irq}, 8'h00);
    // main prescaler table codes; two ticks from FE to the wrap
    for (int k = 1; k < 5; k++) begin
      d = 1 << dpw_pkg::MAIN_LOG2[k];
      wr(dpw_pkg::KEY_CONTROL, 8'h20 | 8'(k));
      wr(dpw_pkg::KEY_COUNTER, 8'hFE);
      wt(0, 4 * d);
      chk(8'(n >= d && n < 2 * d), 8'h01);
      wr(dpw_pkg::KEY_CONTROL, 8'h00);
    end
    run = 1'b1;
    for (int k = 0; k < 8; k++) begin
      wr(dpw_pkg::KEY_CONTROL, 8'h30 | 8'(k));
      wr(dpw_pkg::KEY_COUNTER, 8'hFE);
      subs = 0;
      wt(0, 6000);
      chk(8'(subs >= (2 << k) && subs <= (4 << k) + 1), 8'h01);
      wr(dpw_pkg::KEY_CONTROL, 8'h10);
      chk({7'h00, irq}, 8'h00);
    end
    run = 1'b0;
    wr(dpw_pkg::KEY_CONTROL, 8'h60);
    wr(dpw_pkg::KEY_COUNTER, 8'hFE);
    wt(1, 20);
    chk({7'h00, irq}, 8'h00);
    wr(dpw_pkg::KEY_CONTROL, 8'h68);
    wr(dpw_pkg::KEY_COUNTER, 8'hFE);
    wt(2, 20);
    chk({7'h00, pin_n}, 8'h00);
    rd(1'b0, got);
    chk(got, 8'h00);
    repeat (600) if (irst === 1'b1) cyc1();
    chk({6'h00, irst, pin_n}, 8'h01);
    test_done();
  end
endmodule // dpw_watchdog_tb
